// [shared/intctl_regs.svh]
`ifndef INTCTL_REGS_SVH
`define INTCTL_REGS_SVH

// Byte addresses on the APB bus
`define ADDR_INTERRUPT_CONTROL_ONE 12'h000
`define ADDR_IRQ_STATUS            12'h004
`define ADDR_IRQ_MASK              12'h008
`define ADDR_DISABLE_COUNT         12'h00c

// Field positions in interrupt_control_one, and the number of external inputs
`define BIT_ALT_VECTOR_SELECT      15
`define BIT_DISABLE_ACTIVE         14
`define NUM_EXT_IRQ                3

// Reset values
`define RESET_CONTROL_ONE          16'h0000
`define RESET_EXT_POLARITY         3'h0
`define RESET_IRQ_BITS             3'h0
`define RESET_DISABLE_COUNT        14'h0000

// Widths of the readable words
`define WIDTH_CONTROL_ONE          16
`define WIDTH_DISABLE_COUNT        14

// Timing counts
`define DISABLE_COUNT_STEP         14'h0001
`define EDGE_FILL_CYCLES           2'h3

`endif

// [shared/intctl_pkg.sv]
package intctl_pkg;

	// Layout of the control register, bit 15 down to bit 0
	typedef struct packed {
		logic        alternate_vector_table_select;
		logic        interrupt_disable_active;
		logic [10:0] unused;
		logic        ext_irq2_edge_polarity;
		logic        ext_irq1_edge_polarity;
		logic        ext_irq0_edge_polarity;
	} interrupt_control_one_s;

	// APB request as seen by the slave
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_s;

endpackage : intctl_pkg

// [verilog/edge_detect.sv]
`timescale 1ns/1ns
`include "intctl_regs.svh"

// One external input: two-stage synchroniser and selected-edge detect
module edge_detect #(
	// Edges after reset before the pin history is trusted
	parameter logic [1:0] FILL_CYCLES = `EDGE_FILL_CYCLES
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic reset,
	// Pin and polarity select
	input  wire logic pin_in,
	input  wire logic falling_sel,
	// One-cycle request pulse
	output logic      edge_pulse
);

	logic sync_a_reg;
	logic sync_b_reg;
	logic last_reg;
	logic [1:0] fill_reg;

	// Synchroniser; first stage feeds only the second
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sync_a_reg <= 1'b0;
			sync_b_reg <= 1'b0;
			last_reg   <= 1'b0;
		end else begin
			sync_a_reg <= pin_in;
			sync_b_reg <= sync_a_reg;
			last_reg   <= sync_b_reg;
		end
	end

	// Held off until history is filled: a pin idling high would otherwise
	// look like a rising edge right after reset
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			fill_reg <= 2'h0;
		end else if (fill_reg != FILL_CYCLES) begin
			fill_reg <= fill_reg + 2'h1;
		end
	end

	// Compare pin history only, so a polarity change makes no request
	assign edge_pulse = (fill_reg == FILL_CYCLES) &
	                    (falling_sel ? (last_reg & ~sync_b_reg)    // [R5] [R6]
	                                 : (~last_reg & sync_b_reg));  // [R5] [R6]

endmodule : edge_detect

// [verilog/interrupt_control_config.sv]
`timescale 1ns/1ns
`include "intctl_regs.svh"

// Operation
// (R1) Bit 15 set selects alternate vector table; clear selects the standard table.
// (R2) Bit 14 reads one while interrupt-disable countdown runs; writes ignored.
// (R3) Bits 13 to 3 read zero and ignore writes.
// (R4) Bits 2, 1, 0 are writable edge polarity selects for inputs c, b, a.
// (R5) Polarity one detects falling edge; zero detects rising edge.
// (R6) Inputs synchronised; selected edge sets request flag; polarity change makes none.
module interrupt_control_config (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// External interrupt pins
	input  wire logic        external_irq_input_a,
	input  wire logic        external_irq_input_b,
	input  wire logic        external_irq_input_c,
	// Core side
	input  wire logic        disable_start,
	input  wire logic [13:0] disable_cycles,
	output logic             alternate_vector_table_select,
	output logic             interrupt_disable_active,
	output logic             irq
);

	intctl_pkg::apb_req_s               req;
	intctl_pkg::interrupt_control_one_s ctl_view;
	logic                               alt_vector_reg;
	logic [`NUM_EXT_IRQ-1:0]            polarity_reg;
	logic [`NUM_EXT_IRQ-1:0]            status_reg;
	logic [`NUM_EXT_IRQ-1:0]            mask_reg;
	logic [13:0]                        disable_count_reg;
	logic [`NUM_EXT_IRQ-1:0]            pins;
	logic [`NUM_EXT_IRQ-1:0]            edge_hit;
	logic                               wr_en;
	logic                               rd_en;
	logic                               addr_ok;
	logic [31:0]                        rdata_next;
	// Decoded strobes and helpers
	logic                               access_en;
	logic                               setup_en;
	logic                               sel_ctl;
	logic                               sel_status;
	logic                               sel_mask;
	logic                               sel_count;
	logic                               wr_ctl;
	logic                               wr_mask;
	logic                               rd_status;
	logic                               count_live;
	logic [`NUM_EXT_IRQ-1:0]            status_clear;
	intctl_pkg::interrupt_control_one_s ctl_wr;

	// Bus fields into one struct, pins into one vector
	assign req  = '{psel: psel, penable: penable, pwrite: pwrite,
	                paddr: paddr, pwdata: pwdata};
	assign pins = {external_irq_input_c, external_irq_input_b, external_irq_input_a};

	// Zero-wait slave: every access completes in its first access cycle.
	// Holding pready high keeps the master simple; the cost is that read
	// data must be ready one edge after the address appears.
	assign pready    = 1'b1;
	assign access_en = req.psel & req.penable;
	assign setup_en  = req.psel & ~req.penable;
	assign wr_en     = access_en & req.pwrite;
	assign rd_en     = access_en & ~req.pwrite;

	// Address decode, one select per mapped word
	assign sel_ctl    = (req.paddr == `ADDR_INTERRUPT_CONTROL_ONE);
	assign sel_status = (req.paddr == `ADDR_IRQ_STATUS);
	assign sel_mask   = (req.paddr == `ADDR_IRQ_MASK);
	assign sel_count  = (req.paddr == `ADDR_DISABLE_COUNT);
	assign addr_ok    = sel_ctl | sel_status | sel_mask | sel_count;

	// Unmapped words answer with an error and change nothing
	assign pslverr = access_en & ~addr_ok;

	// Strobes for the registers that react to an access
	assign wr_ctl    = wr_en & sel_ctl;
	assign wr_mask   = wr_en & sel_mask;
	assign rd_status = rd_en & sel_status;

	// Write data seen through the control layout
	assign ctl_wr = req.pwdata[`WIDTH_CONTROL_ONE-1:0];

	// One detector per external input; each owns its own synchroniser,
	// so the three pins may toggle independently of each other
	genvar gi;
	generate
		for (gi = 0; gi < `NUM_EXT_IRQ; gi = gi + 1) begin : g_ext
			edge_detect u_edge (
				.sys_clk     (sys_clk),
				.reset       (reset),
				.pin_in      (pins[gi]),
				.falling_sel (polarity_reg[gi]), // [R5]
				.edge_pulse  (edge_hit[gi])
			);
		end
	endgenerate

	// Vector table select, software owned. The core reads it at every
	// vector fetch, so a change applies from the next fetch on; software
	// should switch it only while no interrupt is being serviced.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			alt_vector_reg <= 1'b0;
		end else if (wr_ctl) begin
			alt_vector_reg <= ctl_wr.alternate_vector_table_select; // [R1]
		end
	end

	// Polarity selects; bits 13..3 and 14 are simply not stored.
	// A polarity write cannot fake a request: the detectors compare
	// pin history only, never the select itself.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			polarity_reg <= `RESET_EXT_POLARITY;
		end else if (wr_ctl) begin
			polarity_reg <= {ctl_wr.ext_irq2_edge_polarity,
			                 ctl_wr.ext_irq1_edge_polarity,
			                 ctl_wr.ext_irq0_edge_polarity}; // [R4] [R3]
		end
	end

	// Interrupt-disable countdown, started by the core. A start pulse
	// always reloads, so a second disable during a running one restarts
	// the window at the new length instead of adding to the old one.
	// The count word is read-only; software cannot shorten the window.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			disable_count_reg <= `RESET_DISABLE_COUNT;
		end else if (disable_start) begin
			disable_count_reg <= disable_cycles;
		end else if (count_live) begin
			disable_count_reg <= disable_count_reg - `DISABLE_COUNT_STEP;
		end
	end

	// Active while countdown nonzero
	assign count_live                    = (disable_count_reg != `RESET_DISABLE_COUNT);
	assign interrupt_disable_active      = count_live; // [R2]
	assign alternate_vector_table_select = alt_vector_reg; // [R1]

	// A status read clears only the bits it returned. The read data was
	// loaded one edge before the clear, so an edge landing in the setup
	// cycle would otherwise be wiped without software ever seeing it.
	// Bits not returned stay set and are reported by the next read.
	assign status_clear = rd_status ? prdata[`NUM_EXT_IRQ-1:0] : `RESET_IRQ_BITS;

	// Sticky request flags; a new edge wins over the read clear
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			status_reg <= `RESET_IRQ_BITS;
		end else begin
			status_reg <= (status_reg & ~status_clear) | edge_hit; // [R6]
		end
	end

	// Mask, same layout as status; masking hides a request but keeps
	// its status bit, so unmasking later raises the line at once
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			mask_reg <= `RESET_IRQ_BITS;
		end else if (wr_mask) begin
			mask_reg <= req.pwdata[`NUM_EXT_IRQ-1:0];
		end
	end

	// Level interrupt, not gated by disable: the core applies that gate.
	// Gating here would hide requests from a core that polls the line
	// while its own disable window runs.
	assign irq = |(status_reg & mask_reg);

	// Register view of the control word; unused positions start at zero
	// and nothing below ever sets them
	always_comb begin
		ctl_view                               = `RESET_CONTROL_ONE;
		ctl_view.alternate_vector_table_select = alt_vector_reg;
		ctl_view.interrupt_disable_active      = interrupt_disable_active; // [R2]
		ctl_view.ext_irq2_edge_polarity        = polarity_reg[2];
		ctl_view.ext_irq1_edge_polarity        = polarity_reg[1];
		ctl_view.ext_irq0_edge_polarity        = polarity_reg[0];
	end

	// Read mux; unused bits stay zero. Unmapped words return zero
	// alongside the error, so a stray read never leaks stale data.
	always_comb begin
		rdata_next = 32'h0000_0000;
		case (req.paddr)
			`ADDR_INTERRUPT_CONTROL_ONE: rdata_next[`WIDTH_CONTROL_ONE-1:0] = ctl_view; // [R3]
			`ADDR_IRQ_STATUS:            rdata_next[`NUM_EXT_IRQ-1:0] = status_reg;
			`ADDR_IRQ_MASK:              rdata_next[`NUM_EXT_IRQ-1:0] = mask_reg;
			`ADDR_DISABLE_COUNT:         rdata_next[`WIDTH_DISABLE_COUNT-1:0] = disable_count_reg;
			default:                     rdata_next = 32'h0000_0000;
		endcase
	end

	// Read data registered in the setup cycle so it is stable in access.
	// Live values such as the countdown are therefore one edge old when
	// the master takes them; the status clear relies on this snapshot.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
		end else if (setup_en) begin
			prdata <= rdata_next;
		end
	end

endmodule : interrupt_control_config

// [testbench/intctl_asserts.sv]
`timescale 1ns/1ns
module intctl_asserts (
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        reset,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	// Core side
	input wire logic        disable_start,
	input wire logic [13:0] disable_cycles,
	input wire logic        alternate_vector_table_select,
	input wire logic        interrupt_disable_active,
	input wire logic        irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// Access phases to the control word
	wire wr_ctl = psel && penable && pwrite && paddr == 12'h000;
	wire rd_ctl = psel && penable && !pwrite && paddr == 12'h000;
	vec_sel_a: assert property (
		wr_ctl |=> alternate_vector_table_select == $past(pwdata[15]))
		else $error("vector select wrong");
	vec_read_a: assert property (
		rd_ctl |-> prdata[15] == $past(alternate_vector_table_select))
		else $error("vector readback wrong");
	disable_len_a: assert property (
		disable_start && disable_cycles == 14'h0003 |=>
		interrupt_disable_active [*3] ##1 !interrupt_disable_active)
		else $error("disable length wrong");
	disable_read_a: assert property (
		rd_ctl |-> prdata[14] == $past(interrupt_disable_active))
		else $error("disable readback wrong");
	unimpl_zero_a: assert property (
		rd_ctl |-> prdata[13:3] == 11'h000)
		else $error("unused bits not zero");
	// Pins are kept quiet around polarity writes by the bench
	pol_quiet_a: assert property (
		wr_ctl |=> (!$rose(irq)) [*5])
		else $error("polarity write raised irq");
	cover property (rd_ctl && prdata[14]);
	cover property ($rose(irq));
	cover property (wr_ctl && pwdata[15]);
endmodule : intctl_asserts

bind interrupt_control_config intctl_asserts chk (.sys_clk(sys_clk), .reset(reset),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .disable_start(disable_start), .disable_cycles(disable_cycles),
	.alternate_vector_table_select(alternate_vector_table_select),
	.interrupt_disable_active(interrupt_disable_active), .irq(irq));

// [testbench/pin_model.sv]
`timescale 1ns/1ns
// Far-side pins; they move only just after a clock edge
module pin_model (
	// Clock
	input  wire logic       sys_clk,
	// Requested levels, bit 0 is input a
	input  wire logic [2:0] level,
	// Pins
	output logic      [2:0] pins = 3'h0
);
	// One cycle of lag, like an outside driver
	always @(posedge sys_clk) pins <= level;
endmodule : pin_model

// [testbench/interrupt_control_config_reg_tb_top.sv]
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
	$display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module interrupt_control_config_reg_tb_top;
	logic        sys_clk = 1'b0;
	logic        reset = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        disable_start = 1'b0;
	logic [13:0] disable_cycles = 14'h0000;
	logic [2:0]  level = 3'h0;
	logic [2:0]  pins;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, err, alt_sel, dis_act, irq;
	int          errors = 0, total_checks = 0, cyc = 0;
	// Clock and hang guard
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			errors++;
			results();
		end
	end
	pin_model far (.sys_clk(sys_clk), .level(level), .pins(pins));
	interrupt_control_config dut (.sys_clk(sys_clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .external_irq_input_a(pins[0]),
		.external_irq_input_b(pins[1]), .external_irq_input_c(pins[2]),
		.disable_start(disable_start), .disable_cycles(disable_cycles),
		.alternate_vector_table_select(alt_sel), .interrupt_disable_active(dis_act), .irq(irq));
	// One APB transfer; a leading edge keeps back-to-back calls apart
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic t_regs();
		apb(1'b0, 12'h010, 32'h0);
		`CHK(err, 1'b1)
		apb(1'b1, 12'h000, 32'hffff_ffff);
		apb(1'b0, 12'h000, 32'h0);
		`CHK(rd, 32'h0000_8007)
		`CHK(err, 1'b0)
		`CHK(alt_sel, 1'b1)
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, 12'h000, 32'h4000 | (32'h1 << i));
			apb(1'b0, 12'h000, 32'h0);
			`CHK(rd, 32'h1 << i)
		end
		`CHK(alt_sel, 1'b0)
		$display("t_regs done");
	endtask : t_regs
	task automatic t_disable();
		disable_cycles <= 14'h0003;
		disable_start <= 1'b1;
		@(posedge sys_clk);
		disable_start <= 1'b0;
		@(negedge sys_clk);
		`CHK(dis_act, 1'b1)
		apb(1'b0, 12'h000, 32'h0);
		`CHK(rd[14], 1'b1)
		repeat (2) @(negedge sys_clk);
		`CHK(dis_act, 1'b0)
		// Longer window: count word read mid-run, one edge old, then expiry
		@(posedge sys_clk);
		disable_cycles <= 14'h0010;
		disable_start <= 1'b1;
		@(posedge sys_clk);
		disable_start <= 1'b0;
		apb(1'b0, 12'h00c, 32'h0);
		`CHK(err, 1'b0)
		`CHK(rd, 32'h0000_000f)
		`CHK(dis_act, 1'b1)
		repeat (16) @(negedge sys_clk);
		`CHK(dis_act, 1'b0)
		$display("t_disable done");
	endtask : t_disable
	// Each pin, both polarities: active edge sets, inactive edge does not
	task automatic t_edge();
		for (int p = 0; p < 2; p++)
			for (int i = 0; i < 3; i++) begin
				level <= {3{p[0]}};
				apb(1'b1, 12'h008, 32'h7);
				repeat (8) @(posedge sys_clk);
				apb(1'b0, 12'h004, 32'h0);
				apb(1'b1, 12'h000, {29'h0, {3{p[0]}}});
				repeat (8) @(negedge sys_clk);
				`CHK(irq, 1'b0)
				@(posedge sys_clk);
				level[i] <= ~p[0];
				repeat (8) @(negedge sys_clk);
				`CHK(irq, 1'b1)
				apb(1'b1, 12'h008, 32'h0);
				@(negedge sys_clk);
				`CHK(irq, 1'b0)
				apb(1'b0, 12'h004, 32'h0);
				`CHK(rd, 32'h1 << i)
				apb(1'b0, 12'h004, 32'h0);
				`CHK(rd, 32'h0)
				@(posedge sys_clk);
				level[i] <= p[0];
				apb(1'b1, 12'h008, 32'h7);
				repeat (8) @(negedge sys_clk);
				`CHK(irq, 1'b0)
			end
		$display("t_edge done");
	endtask : t_edge
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : results
	initial begin
		repeat (12) @(posedge sys_clk);
		reset <= 1'b0;
		t_regs();
		t_disable();
		t_edge();
		results();
	end
endmodule : interrupt_control_config_reg_tb_top
